// File: ct16_cfg.svh
`ifndef CT16_CFG_SVH
`define CT16_CFG_SVH

// register byte offsets
`define CT16_OFS_LOW_MODE 6'h00
`define CT16_OFS_HIGH_MODE 6'h04
`define CT16_OFS_LOW_CLKSEL 6'h08
`define CT16_OFS_HIGH_CLKSEL 6'h0c
`define CT16_OFS_LOW_CMP 6'h10
`define CT16_OFS_HIGH_CMP 6'h14
`define CT16_OFS_LOW_CNT 6'h18
`define CT16_OFS_HIGH_CNT 6'h1c

// mode control field positions
`define CT16_BIT_ENABLE 7
`define CT16_BIT_CASCADE 4
`define CT16_BIT_SET_HIGH 3
`define CT16_BIT_SET_LOW 2
`define CT16_BIT_TOGGLE 1
`define CT16_BIT_OUT_EN 0

// reset values
`define CT16_RST_MODE 8'h00
`define CT16_RST_CLKSEL 3'h0
`define CT16_RST_CMP 8'h00
`define CT16_RST_CNT 8'h00

// prescaler taps, as powers of two of the main clock
`define CT16_TAP_2 3
`define CT16_TAP_3 5
`define CT16_TAP_4 7
`define CT16_TAP_5 8
`define CT16_TAP_6 9
`define CT16_TAP_7 11
`define CT16_PRE_W 11

`endif

// File: ct16_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module ct16_event_src (
    input wire logic clk,
    output logic ev_lo,
    output logic ev_hi
);
    initial begin
        ev_lo = 1'b0;
        ev_hi = 1'b1;
    end
    // high and low phases each last at least one clock, so every
    // input cycle is seen by the synchronous edge detect
    task automatic burst(input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            ev_lo <= 1'b1;
            ev_hi <= ~ev_hi;
            repeat (gap) @(posedge clk);
            ev_lo <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: ct16_pkg.sv
package ct16_pkg;
    typedef logic [7:0] ct16_byte_t;
    typedef logic [2:0] ct16_clksel_t;
    typedef enum logic [1:0] {
        CT16_BUS_IDLE = 2'b01,
        CT16_BUS_ACK = 2'b10
    } ct16_bus_st_t;
endpackage

// File: ct16_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "ct16_cfg.svh"
module ct16_prescale (
    input wire logic clk,
    input wire logic rst_n,
    input wire ct16_pkg::ct16_clksel_t sel,
    input wire logic event_in,
    output logic tick
);
    import ct16_pkg::*;

    logic [`CT16_PRE_W-1:0] pre_ff;
    logic [`CT16_PRE_W-1:0] nxt_pre;
    logic evt_prev_ff;
    logic nxt_evt_prev;
    logic tick_ff;
    logic nxt_tick;

    // true when the low bits of the prescaler are all ones for this code
    function automatic logic tap_hit(input ct16_clksel_t s,
                                     input logic [`CT16_PRE_W-1:0] p);
        logic [`CT16_PRE_W-1:0] m;
        m = '0;
        case (s)
            3'h2: m = `CT16_PRE_W'((1 << `CT16_TAP_2) - 1);
            3'h3: m = `CT16_PRE_W'((1 << `CT16_TAP_3) - 1);
            3'h4: m = `CT16_PRE_W'((1 << `CT16_TAP_4) - 1);
            3'h5: m = `CT16_PRE_W'((1 << `CT16_TAP_5) - 1);
            3'h6: m = `CT16_PRE_W'((1 << `CT16_TAP_6) - 1);
            default: m = `CT16_PRE_W'((1 << `CT16_TAP_7) - 1);
        endcase
        return (p & m) == m;
    endfunction

    always_comb begin
        // free running: a start lands anywhere in the period
        nxt_pre = pre_ff + `CT16_PRE_W'(1);
        nxt_evt_prev = event_in;
        if (sel == 3'h0 || sel == 3'h1) begin
            nxt_tick = event_in & ~evt_prev_ff;
        end else begin
            nxt_tick = tap_hit(sel, pre_ff);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= '0;
            evt_prev_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            evt_prev_ff <= nxt_evt_prev;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

// File: ct16_timer.sv
// Functional notes
// - high mode cascade bit set joins both halves into one 16-bit counter.
// - each half's enable bit starts counting at 1, stops at 0.
// - 16-bit compare is low compare as low byte, high compare high byte.
// - in cascade the count clock comes only from low clock select.
// - on 16-bit match raise cascade interrupt and clear both halves.
// - after match the counter keeps running, so matches recur periodically.
// - high half still flags its own match in cascade mode.
// - in cascade the low enable alone starts and stops everything.
// - clock codes 0,1 external; others divide by 2^3,5,7,8,9,11.
// - external clocking resolves one input cycle, up to 2^16 cycles.
// - low square-wave output toggles on each 16-bit match, except in a cycle where low mode is written.
// - first match may be up to one count clock early after start.
// - compare zero is allowed; external input then matches every pulse.
// - compare lowered below count makes the counter wrap before matching.
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ct16_cfg.svh"
module ct16_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic external_event_input,
    input wire logic high_event_input,
    output logic cascade_match_interrupt,
    output logic high_half_match_interrupt,
    output logic low_square_out,
    output logic high_square_out
);
    import ct16_pkg::*;

    // bus handshake state
    ct16_bus_st_t bus_st_ff;
    ct16_bus_st_t nxt_bus_st;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_go;

    // software registers
    ct16_byte_t low_mode_control_ff;
    ct16_byte_t nxt_low_mode_control;
    ct16_byte_t high_mode_control_ff;
    ct16_byte_t nxt_high_mode_control;
    ct16_clksel_t low_clock_select_ff;
    ct16_clksel_t nxt_low_clock_select;
    ct16_clksel_t high_clock_select_ff;
    ct16_clksel_t nxt_high_clock_select;
    ct16_byte_t low_compare_register_ff;
    ct16_byte_t nxt_low_compare_register;
    ct16_byte_t high_compare_register_ff;
    ct16_byte_t nxt_high_compare_register;

    // counters and outputs
    ct16_byte_t low_count_register_ff;
    ct16_byte_t nxt_low_count_register;
    ct16_byte_t high_count_register_ff;
    ct16_byte_t nxt_high_count_register;
    logic casc_irq_ff;
    logic nxt_casc_irq;
    logic high_irq_ff;
    logic nxt_high_irq;
    logic low_lvl_ff;
    logic nxt_low_lvl;
    logic high_lvl_ff;
    logic nxt_high_lvl;
    logic low_sq_ff;
    logic nxt_low_sq;
    logic high_sq_ff;
    logic nxt_high_sq;

    logic tick_low;
    logic tick_high;
    logic cascade_sel;
    logic low_count_enable;
    logic high_count_enable;
    logic run_low;
    logic run_high;
    logic match16;
    logic low_match;
    logic high_match;
    logic low_wrap;

    // word offset of a byte address; the two low bits are ignored
    function automatic logic [5:0] word_ofs(input logic [5:0] a);
        return {a[5:2], 2'b00};
    endfunction

    ct16_prescale u_pre_low (
        .clk(clk),
        .rst_n(rst_n),
        .sel(low_clock_select_ff),
        .event_in(external_event_input),
        .tick(tick_low)
    );

    ct16_prescale u_pre_high (
        .clk(clk),
        .rst_n(rst_n),
        .sel(high_clock_select_ff),
        .event_in(high_event_input),
        .tick(tick_high)
    );

    // one wait cycle per access; the access takes effect when it drops
    always_comb begin
        nxt_bus_st = CT16_BUS_IDLE;
        nxt_rdata = rdata_ff;
        wr_go = 1'b0;
        case (bus_st_ff)
            CT16_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_bus_st = CT16_BUS_ACK;
                    nxt_rdata = '0;
                    case (word_ofs(avs_address))
                        `CT16_OFS_LOW_MODE:
                            nxt_rdata[7:0] = low_mode_control_ff;
                        `CT16_OFS_HIGH_MODE:
                            nxt_rdata[7:0] = high_mode_control_ff;
                        `CT16_OFS_LOW_CLKSEL:
                            nxt_rdata[2:0] = low_clock_select_ff;
                        `CT16_OFS_HIGH_CLKSEL:
                            nxt_rdata[2:0] = high_clock_select_ff;
                        `CT16_OFS_LOW_CMP:
                            nxt_rdata[7:0] = low_compare_register_ff;
                        `CT16_OFS_HIGH_CMP:
                            nxt_rdata[7:0] = high_compare_register_ff;
                        `CT16_OFS_LOW_CNT:
                            nxt_rdata[7:0] = low_count_register_ff;
                        `CT16_OFS_HIGH_CNT:
                            nxt_rdata[7:0] = high_count_register_ff;
                        default: nxt_rdata = '0;
                    endcase
                end
            end
            CT16_BUS_ACK: begin
                nxt_bus_st = CT16_BUS_IDLE;
                wr_go = avs_write & avs_byteenable[0];
            end
            default: nxt_bus_st = CT16_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_ff <= CT16_BUS_IDLE;
            rdata_ff <= '0;
        end else begin
            bus_st_ff <= nxt_bus_st;
            rdata_ff <= nxt_rdata;
        end
    end

    // register writes; level set bits act once and are not stored
    always_comb begin
        nxt_low_mode_control = low_mode_control_ff;
        nxt_high_mode_control = high_mode_control_ff;
        nxt_low_clock_select = low_clock_select_ff;
        nxt_high_clock_select = high_clock_select_ff;
        nxt_low_compare_register = low_compare_register_ff;
        nxt_high_compare_register = high_compare_register_ff;
        if (wr_go) begin
            case (word_ofs(avs_address))
                `CT16_OFS_LOW_MODE: begin
                    nxt_low_mode_control = avs_writedata[7:0] & 8'h83;
                end
                `CT16_OFS_HIGH_MODE: begin
                    nxt_high_mode_control = avs_writedata[7:0] & 8'h93;
                end
                `CT16_OFS_LOW_CLKSEL: begin
                    nxt_low_clock_select = avs_writedata[2:0];
                end
                `CT16_OFS_HIGH_CLKSEL: begin
                    nxt_high_clock_select = avs_writedata[2:0];
                end
                `CT16_OFS_LOW_CMP: begin
                    nxt_low_compare_register = avs_writedata[7:0];
                end
                `CT16_OFS_HIGH_CMP: begin
                    nxt_high_compare_register = avs_writedata[7:0];
                end
                default: begin
                    nxt_low_mode_control = low_mode_control_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_mode_control_ff <= `CT16_RST_MODE;
            high_mode_control_ff <= `CT16_RST_MODE;
            low_clock_select_ff <= `CT16_RST_CLKSEL;
            high_clock_select_ff <= `CT16_RST_CLKSEL;
            low_compare_register_ff <= `CT16_RST_CMP;
            high_compare_register_ff <= `CT16_RST_CMP;
        end else begin
            low_mode_control_ff <= nxt_low_mode_control;
            high_mode_control_ff <= nxt_high_mode_control;
            low_clock_select_ff <= nxt_low_clock_select;
            high_clock_select_ff <= nxt_high_clock_select;
            low_compare_register_ff <= nxt_low_compare_register;
            high_compare_register_ff <= nxt_high_compare_register;
        end
    end

    assign cascade_sel = high_mode_control_ff[`CT16_BIT_CASCADE];
    assign low_count_enable = low_mode_control_ff[`CT16_BIT_ENABLE];
    assign high_count_enable = high_mode_control_ff[`CT16_BIT_ENABLE];
    assign run_low = low_count_enable;
    // cascade: low enable alone runs both halves
    assign run_high = cascade_sel ? low_count_enable : high_count_enable;
    assign match16 = cascade_sel && tick_low &&
        ({high_count_register_ff, low_count_register_ff} ==
         {high_compare_register_ff, low_compare_register_ff});
    assign low_match = low_count_register_ff == low_compare_register_ff;
    assign high_match = high_count_register_ff == high_compare_register_ff;
    assign low_wrap = low_count_register_ff == 8'hff;

    // counting; a stopped half holds zero
    always_comb begin
        nxt_low_count_register = low_count_register_ff;
        nxt_high_count_register = high_count_register_ff;
        nxt_casc_irq = 1'b0;
        nxt_high_irq = 1'b0;
        if (!run_low) begin
            nxt_low_count_register = `CT16_RST_CNT;
        end else if (tick_low) begin
            if (cascade_sel ? match16 : low_match) begin
                nxt_low_count_register = `CT16_RST_CNT;
                nxt_casc_irq = 1'b1;
            end else begin
                // past the compare it runs on through ff to 00
                nxt_low_count_register = low_count_register_ff + 8'h01;
            end
        end
        if (!run_high) begin
            nxt_high_count_register = `CT16_RST_CNT;
        end else if (cascade_sel) begin
            if (match16) begin
                nxt_high_count_register = `CT16_RST_CNT;
            end else if (tick_low && low_wrap) begin
                nxt_high_count_register =
                    high_count_register_ff + 8'h01;
            end
            // own match still flagged when the high count steps onto it
            nxt_high_irq = (nxt_high_count_register !=
                            high_count_register_ff) &&
                           (nxt_high_count_register ==
                            high_compare_register_ff);
        end else if (tick_high) begin
            if (high_match) begin
                nxt_high_count_register = `CT16_RST_CNT;
                nxt_high_irq = 1'b1;
            end else begin
                nxt_high_count_register = high_count_register_ff + 8'h01;
            end
        end
    end

    // square wave levels; set bits force the level, match inverts it
    always_comb begin
        nxt_low_lvl = low_lvl_ff;
        nxt_high_lvl = high_lvl_ff;
        if (wr_go && word_ofs(avs_address) == `CT16_OFS_LOW_MODE) begin
            if (avs_writedata[`CT16_BIT_SET_HIGH]) begin
                nxt_low_lvl = 1'b1;
            end else if (avs_writedata[`CT16_BIT_SET_LOW]) begin
                nxt_low_lvl = 1'b0;
            end
        end else if (nxt_casc_irq &&
                     low_mode_control_ff[`CT16_BIT_TOGGLE]) begin
            nxt_low_lvl = ~low_lvl_ff;
        end
        if (wr_go && word_ofs(avs_address) == `CT16_OFS_HIGH_MODE) begin
            if (avs_writedata[`CT16_BIT_SET_HIGH]) begin
                nxt_high_lvl = 1'b1;
            end else if (avs_writedata[`CT16_BIT_SET_LOW]) begin
                nxt_high_lvl = 1'b0;
            end
        end else if (nxt_high_irq && !cascade_sel &&
                     high_mode_control_ff[`CT16_BIT_TOGGLE]) begin
            // in cascade the high pin stays put: its match is not the period
            nxt_high_lvl = ~high_lvl_ff;
        end
        nxt_low_sq = low_mode_control_ff[`CT16_BIT_OUT_EN] & low_lvl_ff;
        nxt_high_sq = high_mode_control_ff[`CT16_BIT_OUT_EN] & high_lvl_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_count_register_ff <= `CT16_RST_CNT;
            high_count_register_ff <= `CT16_RST_CNT;
            casc_irq_ff <= 1'b0;
            high_irq_ff <= 1'b0;
            low_lvl_ff <= 1'b0;
            high_lvl_ff <= 1'b0;
            low_sq_ff <= 1'b0;
            high_sq_ff <= 1'b0;
        end else begin
            low_count_register_ff <= nxt_low_count_register;
            high_count_register_ff <= nxt_high_count_register;
            casc_irq_ff <= nxt_casc_irq;
            high_irq_ff <= nxt_high_irq;
            low_lvl_ff <= nxt_low_lvl;
            high_lvl_ff <= nxt_high_lvl;
            low_sq_ff <= nxt_low_sq;
            high_sq_ff <= nxt_high_sq;
        end
    end

    assign avs_readdata = rdata_ff;
    // idle code has bit 0 set, so wait is a bare state flop bit
    assign avs_waitrequest = bus_st_ff[0];
    assign cascade_match_interrupt = casc_irq_ff;
    assign high_half_match_interrupt = high_irq_ff;
    assign low_square_out = low_sq_ff;
    assign high_square_out = high_sq_ff;
endmodule
`default_nettype wire

// File: ct16_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ct16_timer_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cascade_match_interrupt,
    input wire logic high_half_match_interrupt,
    input wire logic low_square_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ack_latency_a: assert property (
        ($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    ack_single_a: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_needs_req_a: assert property (
        (!avs_read && !avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    read_upper_a: assert property (
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    match_pulse_a: assert property (
        cascade_match_interrupt |=> !cascade_match_interrupt)
        else $error("cascade interrupt longer than one cycle");
    high_pulse_a: assert property (
        high_half_match_interrupt |=> !high_half_match_interrupt)
        else $error("high interrupt longer than one cycle");
    release_quiet_a: assert property (
        $rose(rst_n) |-> avs_waitrequest && !cascade_match_interrupt
            && !low_square_out)
        else $error("outputs active at reset release");
    square_cause_a: assert property (
        $changed(low_square_out) |-> $past(cascade_match_interrupt)
            || $past(cascade_match_interrupt, 2) || $past(avs_write, 2)
            || $past(avs_write, 3))
        else $error("square output moved without a match");
endmodule
bind ct16_timer ct16_timer_checker ct16_timer_checker_inst (
    .clk(clk),
    .rst_n(rst_n),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cascade_match_interrupt(cascade_match_interrupt),
    .high_half_match_interrupt(high_half_match_interrupt),
    .low_square_out(low_square_out)
);
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ct16_cfg.svh"
module tb_top;
    import ct16_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cascade_match_interrupt;
    logic high_half_match_interrupt;
    logic low_square_out;
    logic high_square_out;
    logic ev_lo;
    logic ev_hi;
    logic [31:0] q;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_irq = 0;
    int seed = 72;

    always #2.5 clk = ~clk;

    ct16_timer ct16_timer_inst (
        .clk(clk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .external_event_input(ev_lo),
        .high_event_input(ev_hi),
        .cascade_match_interrupt(cascade_match_interrupt),
        .high_half_match_interrupt(high_half_match_interrupt),
        .low_square_out(low_square_out),
        .high_square_out(high_square_out)
    );
    ct16_event_src ct16_event_src_inst (
        .clk(clk),
        .ev_lo(ev_lo),
        .ev_hi(ev_hi)
    );

    always @(posedge clk) begin
        if (cascade_match_interrupt === 1'b1) n_irq++;
    end

    function automatic int exp_div(input logic [2:0] code);
        case (code)
            3'h2: return 8;
            3'h3: return 32;
            3'h4: return 128;
            3'h5: return 256;
            3'h6: return 512;
            3'h7: return 2048;
            default: return 1;
        endcase
    endfunction

    task close_out;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one idle cycle before each request keeps drop and raise apart
    task bus(input logic [5:0] a, input logic w, input logic [7:0] d,
             input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) chk("waitrequest", 32'h0, 32'h1);
    endtask

    task wr(input logic [5:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask

    task rd_chk(input string nm, input logic [5:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        chk(nm, {24'h0, e}, q);
    endtask

    // cycles between two matches, high-half pulses and square toggle
    task measure(input int exp, output int hp);
        int n;
        logic s0;
        hp = 0;
        n = 0;
        s0 = 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (cascade_match_interrupt !== 1'b1 && n < 20000);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (high_half_match_interrupt === 1'b1) hp++;
            if (n == 3) s0 = low_square_out;
        end while (cascade_match_interrupt !== 1'b1 && n < 20000);
        chk("match period", exp, n);
        repeat (3) @(posedge clk);
        chk("square out", {31'h0, ~s0}, {31'h0, low_square_out});
    endtask

    initial begin
        int k;
        int hp;
        logic [31:0] r;
        logic [7:0] c;
        logic s;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            rd_chk("reset value", 6'(k * 4), 8'h00);
        end
        rd_chk("unmapped", 6'h20, 8'h00);
        for (k = 0; k < 6; k++) begin
            r = $random(seed);
            c = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : r[7:0];
            wr(`CT16_OFS_LOW_CMP, c);
            rd_chk("low compare", `CT16_OFS_LOW_CMP, c);
            wr(`CT16_OFS_HIGH_CMP, ~c);
            rd_chk("high compare", `CT16_OFS_HIGH_CMP, ~c);
            wr(`CT16_OFS_LOW_CLKSEL, r[15:8]);
            rd_chk("clock select", `CT16_OFS_LOW_CLKSEL, {5'h0, r[10:8]});
        end
        bus(`CT16_OFS_LOW_CMP, 1'b1, ~c, 4'h0);
        rd_chk("masked write", `CT16_OFS_LOW_CMP, c);
        wr(`CT16_OFS_HIGH_MODE, 8'h90);
        wr(`CT16_OFS_LOW_CLKSEL, 8'h02);
        wr(`CT16_OFS_LOW_CMP, 8'h02);
        wr(`CT16_OFS_HIGH_CMP, 8'h01);
        wr(`CT16_OFS_LOW_MODE, 8'h83);
        measure(259 * 8, hp);
        chk("high pulses", 32'h1, hp);
        for (k = 2; k < 8; k++) begin
            wr(`CT16_OFS_LOW_MODE, 8'h00);
            rd_chk("stopped low", `CT16_OFS_LOW_CNT, 8'h00);
            rd_chk("stopped high", `CT16_OFS_HIGH_CNT, 8'h00);
            r = $random(seed);
            wr(`CT16_OFS_LOW_CMP, {6'h0, r[1:0]});
            wr(`CT16_OFS_HIGH_CMP, 8'h00);
            wr(`CT16_OFS_LOW_CLKSEL, 8'(k));
            wr(`CT16_OFS_LOW_MODE, 8'h83);
            measure((r[1:0] + 1) * exp_div(3'(k)), hp);
        end
        wr(`CT16_OFS_LOW_MODE, 8'h00);
        wr(`CT16_OFS_LOW_CLKSEL, {7'h0, r[2]});
        wr(`CT16_OFS_LOW_CMP, 8'hff);
        wr(`CT16_OFS_HIGH_CMP, 8'hff);
        wr(`CT16_OFS_LOW_MODE, 8'h80);
        ct16_event_src_inst.burst(300, 1 + r[4:3]);
        repeat (8) @(posedge clk);
        rd_chk("event low", `CT16_OFS_LOW_CNT, 8'h2c);
        rd_chk("event high", `CT16_OFS_HIGH_CNT, 8'h01);
        wr(`CT16_OFS_LOW_MODE, 8'h00);
        wr(`CT16_OFS_LOW_CMP, 8'h00);
        wr(`CT16_OFS_HIGH_CMP, 8'h00);
        wr(`CT16_OFS_LOW_MODE, 8'h80);
        n_irq = 0;
        ct16_event_src_inst.burst(20, 1);
        repeat (8) @(posedge clk);
        chk("zero compare", 32'd20, n_irq);
        wr(`CT16_OFS_LOW_MODE, 8'h00);
        n_irq = 0;
        ct16_event_src_inst.burst(5, 1);
        repeat (8) @(posedge clk);
        chk("stopped irq", 32'd0, n_irq);
        wr(`CT16_OFS_LOW_MODE, 8'h09);
        repeat (2) @(posedge clk);
        chk("forced high", 32'h1, {31'h0, low_square_out});
        wr(`CT16_OFS_LOW_MODE, 8'h05);
        repeat (2) @(posedge clk);
        chk("forced low", 32'h0, {31'h0, low_square_out});
        wr(`CT16_OFS_HIGH_MODE, 8'h00);
        wr(`CT16_OFS_HIGH_CLKSEL, 8'h02);
        wr(`CT16_OFS_HIGH_CMP, 8'h01);
        wr(`CT16_OFS_HIGH_MODE, 8'h83);
        do begin
            @(posedge clk);
        end while (high_half_match_interrupt !== 1'b1);
        repeat (3) @(posedge clk);
        s = high_square_out;
        repeat (13) @(posedge clk);
        chk("high period", 32'h1, {31'h0, high_half_match_interrupt});
        repeat (3) @(posedge clk);
        chk("high square", {31'h0, ~s}, {31'h0, high_square_out});
        wr(`CT16_OFS_LOW_CMP, 8'h10);
        wr(`CT16_OFS_LOW_MODE, 8'h80);
        ct16_event_src_inst.burst(8, 1);
        wr(`CT16_OFS_LOW_CMP, 8'h04);
        n_irq = 0;
        ct16_event_src_inst.burst(252, 1);
        repeat (8) @(posedge clk);
        chk("no early match", 32'd0, n_irq);
        rd_chk("wrapped count", `CT16_OFS_LOW_CNT, 8'h04);
        ct16_event_src_inst.burst(1, 1);
        repeat (8) @(posedge clk);
        chk("late match", 32'd1, n_irq);
        wr(`CT16_OFS_LOW_MODE, 8'h00);
        wr(`CT16_OFS_LOW_MODE, 8'h80);
        n_irq = 0;
        ct16_event_src_inst.burst(5, 1);
        repeat (8) @(posedge clk);
        chk("restart match", 32'd1, n_irq);
        close_out;
    end

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
endmodule
`default_nettype wire
